//--- ccm_host_model.sv
// Purpose: host side of the register bus, a classic Wishbone master
// Assumes: tasks are entered just after a rising clock edge
// Notes: a transfer that sees no ack within 20 cycles reports ok = 0
`timescale 1ns/1ps
`default_nettype none

module ccm_host_model (
	// Clock
	input wire logic clk_in,
	// Wishbone master
	output logic cyc_out,
	output logic stb_out,
	output logic we_out,
	output logic [9:0] adr_out,
	output logic [3:0] sel_out,
	output logic [31:0] dat_out,
	input wire logic [31:0] dat_in,
	input wire logic ack_in
);
	initial begin
		cyc_out = 1'b0;
		stb_out = 1'b0;
		we_out = 1'b0;
		adr_out = 10'h000;
		sel_out = 4'h0;
		dat_out = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////
	// Request held until the edge that samples ack, then released
	task automatic xfer(input logic we, input logic [9:0] a, input logic [15:0] d,
		output logic [31:0] q, output bit ok);
		int n;
		ok = 1'b0;
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out <= we;
		adr_out <= a;
		sel_out <= 4'h3;
		dat_out <= {16'h0000, d};
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clk_in);
			if (ack_in === 1'b1) begin
				ok = 1'b1;
			end
		end
		q = dat_in;
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		we_out <= 1'b0;
		// Idle cycle between transfers
		@(posedge clk_in);
	endtask
endmodule

`default_nettype wire

//--- ccm_pkg.sv
// Purpose: constants and decode helpers for the codec clock divider and mixer register bank
// Assumes: Wishbone register index = printed offset, byte address = 4 * index
// Notes: all divider figures are counts of the clock that feeds each divider
//
// Overview of operation
// - Debounce divider code picks reference divide 256,2048,...,65536,131072.
// - Pin clock divider code picks system clock divide 1,2,3,4,6,8,12,16.
// - Timeout divider code picks reference divide 256 up to 32768.
// - Reference divider field is writable only under the key, resets 47, divides by n+1.
// - Reference divider changes only after the security key is written.
// - Left mute bit 3, right mute bit 2, one mutes, both reset zero.
// - Left mixer enabled by its bit 1 or the left input path enable.
// - Right mixer enabled by its bit 0 or the right input path enable.
// - Left second-input gain bits 8:6, reset 101, -12dB to +6dB in 3dB.
// - Left third-input gain bits 2:0, same decode and reset as second input.
// - Left amplifier gain bits 5:3 decode 0,6,13,18,20,24,27,29 dB.
// - Right second-input gain bits 8:6, reset 101, same 3dB decode.
// - Right amplifier gain bits 5:3 decode 0,6,13,18,20,24,27,29 dB.
// - Right third-input gain bits 2:0, reset 101, same 3dB decode.
// - Left selects: second input bit 5, third bit 4, amplifier bit 3 resets one.
// - Right selects: second input bit 2, third bit 1, amplifier bit 0 resets one.
// - Input path enable turns on that side's amplifier and mixer.
// - Divided clock reaches the pin only while the pin clock enable is one.

package ccm_pkg;

	localparam logic [7:0] IDX_CLOCK_DIVIDER_CONFIG = 8'h1e;
	localparam logic [7:0] IDX_INPUT_MIXER_CONTROL = 8'h1f;
	localparam logic [7:0] IDX_LEFT_MIXER_GAINS = 8'h20;
	localparam logic [7:0] IDX_RIGHT_MIXER_GAINS = 8'h21;
	localparam logic [7:0] IDX_MIXER_SOURCE_SELECT = 8'h22;
	localparam logic [7:0] IDX_SECURITY_KEY = 8'h40;

	localparam int DBDIV_LSB = 13;
	localparam int PINDIV_LSB = 10;
	localparam int TODIV_LSB = 7;
	localparam int REFDIV_LSB = 1;
	localparam int LMUTE_BIT = 3;
	localparam int RMUTE_BIT = 2;
	localparam int LEN_BIT = 1;
	localparam int REN_BIT = 0;
	localparam int SECOND_GAIN_LSB = 6;
	localparam int AMP_GAIN_LSB = 3;
	localparam int THIRD_GAIN_LSB = 0;
	localparam int LSEL_SECOND_BIT = 5;
	localparam int LSEL_THIRD_BIT = 4;
	localparam int LSEL_AMP_BIT = 3;
	localparam int RSEL_SECOND_BIT = 2;
	localparam int RSEL_THIRD_BIT = 1;
	localparam int RSEL_AMP_BIT = 0;

	localparam logic [5:0] REFDIV_RESET = 6'h2f;
	localparam logic [15:0] CLKCFG_RESET = 16'h005e;
	localparam logic [15:0] MIXCTL_RESET = 16'h0000;
	localparam logic [15:0] GAINS_RESET = 16'h0145;
	localparam logic [15:0] SELECT_RESET = 16'h0009;
	localparam logic [15:0] CLKCFG_MASK = 16'hfffe;
	localparam logic [15:0] REFDIV_MASK = 16'h007e;
	localparam logic [15:0] MIXCTL_MASK = 16'h000f;
	localparam logic [15:0] GAINS_MASK = 16'h01ff;
	localparam logic [15:0] SELECT_MASK = 16'h003f;
	// Arbitrary key value
	localparam logic [15:0] KEY_VALUE = 16'h5a3c;

	function automatic logic [17:0] debounce_period(input logic [2:0] code);
		case (code)
			3'h0: debounce_period = 18'h0_0100;
			3'h1: debounce_period = 18'h0_0800;
			3'h2: debounce_period = 18'h0_1000;
			3'h3: debounce_period = 18'h0_2000;
			3'h4: debounce_period = 18'h0_4000;
			3'h5: debounce_period = 18'h0_8000;
			3'h6: debounce_period = 18'h1_0000;
			default: debounce_period = 18'h2_0000;
		endcase
	endfunction

	function automatic logic [17:0] timeout_period(input logic [2:0] code);
		timeout_period = 18'h0_0100 << code;
	endfunction

	function automatic logic [4:0] pin_period(input logic [2:0] code);
		case (code)
			3'h0: pin_period = 5'h01;
			3'h1: pin_period = 5'h02;
			3'h2: pin_period = 5'h03;
			3'h3: pin_period = 5'h04;
			3'h4: pin_period = 5'h06;
			3'h5: pin_period = 5'h08;
			3'h6: pin_period = 5'h0c;
			default: pin_period = 5'h10;
		endcase
	endfunction

	// Signed dB for the second and third input paths
	function automatic logic signed [5:0] input_gain_db(input logic [2:0] code);
		if (code <= 3'h1) begin
			input_gain_db = -6'sd12;
		end else begin
			input_gain_db = 6'(3 * int'(code) - 15);
		end
	endfunction

	function automatic logic signed [5:0] amp_gain_db(input logic [2:0] code);
		case (code)
			3'h0: amp_gain_db = 6'sd0;
			3'h1: amp_gain_db = 6'sd6;
			3'h2: amp_gain_db = 6'sd13;
			3'h3: amp_gain_db = 6'sd18;
			3'h4: amp_gain_db = 6'sd20;
			3'h5: amp_gain_db = 6'sd24;
			3'h6: amp_gain_db = 6'sd27;
			default: amp_gain_db = 6'sd29;
		endcase
	endfunction

endpackage

//--- ccm_regs.sv
// Purpose: clock divider and input mixer register bank on a classic Wishbone slave
// Assumes: core_clk_in is the system clock; path and pin enables come from same-clock logic
// Notes: every access is answered one cycle after it is taken; unmapped reads return zero
`timescale 1ns/1ps
`default_nettype none

module ccm_regs (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [9:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Enables from the power control bank
	input wire logic left_input_path_enable_in,
	input wire logic right_input_path_enable_in,
	input wire logic pin_clock_output_enable_in,
	// Divided clocks
	output logic reference_clock_tick_out,
	output logic debounce_clock_out,
	output logic timeout_clock_out,
	output logic pin_clock_out,
	output logic pin_clock_oe_out,
	// Left mixer
	output logic left_amp_enable_out,
	output logic left_mixer_enable_out,
	output logic left_mixer_mute_out,
	output logic left_second_input_select_out,
	output logic left_third_input_select_out,
	output logic left_amp_select_out,
	output logic signed [5:0] left_second_input_gain_out,
	output logic signed [5:0] left_amp_to_mixer_gain_out,
	output logic signed [5:0] left_third_input_gain_out,
	// Right mixer
	output logic right_amp_enable_out,
	output logic right_mixer_enable_out,
	output logic right_mixer_mute_out,
	output logic right_second_input_select_out,
	output logic right_third_input_select_out,
	output logic right_amp_select_out,
	output logic signed [5:0] right_second_input_gain_out,
	output logic signed [5:0] right_amp_to_mixer_gain_out,
	output logic signed [5:0] right_third_input_gain_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave and register file

	logic [15:0] clkcfg_reg;
	logic [15:0] clkcfg_next;
	logic [15:0] mixctl_reg;
	logic [15:0] mixctl_next;
	logic [15:0] lgain_reg;
	logic [15:0] lgain_next;
	logic [15:0] rgain_reg;
	logic [15:0] rgain_next;
	logic [15:0] select_reg;
	logic [15:0] select_next;
	logic key_open_reg;
	logic key_open_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	logic req;
	logic wr_commit;
	logic [7:0] idx;
	logic [15:0] wmask;
	logic [15:0] wdata;

	assign req = wb_cyc_in && wb_stb_in;
	// Writes land on the edge where the master sees ack, never earlier
	assign wr_commit = req && wb_we_in && ack_reg;
	assign idx = wb_adr_in[9:2];
	assign wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	assign wdata = wb_dat_in[15:0];

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] keep_mask,
		input logic [15:0] lanes, input logic [15:0] data);
		merge = ((old & ~lanes) | (data & lanes)) & keep_mask;
	endfunction

	always_comb begin
		clkcfg_next = clkcfg_reg;
		mixctl_next = mixctl_reg;
		lgain_next = lgain_reg;
		rgain_next = rgain_reg;
		select_next = select_reg;
		key_open_next = key_open_reg;
		ack_next = req && !ack_reg;
		rdata_next = 32'h0000_0000;
		if (req && !ack_reg && !wb_we_in) begin
			case (idx)
				ccm_pkg::IDX_CLOCK_DIVIDER_CONFIG: rdata_next = {16'h0000, clkcfg_reg};
				ccm_pkg::IDX_INPUT_MIXER_CONTROL: rdata_next = {16'h0000, mixctl_reg};
				ccm_pkg::IDX_LEFT_MIXER_GAINS: rdata_next = {16'h0000, lgain_reg};
				ccm_pkg::IDX_RIGHT_MIXER_GAINS: rdata_next = {16'h0000, rgain_reg};
				ccm_pkg::IDX_MIXER_SOURCE_SELECT: rdata_next = {16'h0000, select_reg};
				ccm_pkg::IDX_SECURITY_KEY: rdata_next = {31'h0000_0000, key_open_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		if (wr_commit) begin
			case (idx)
				ccm_pkg::IDX_CLOCK_DIVIDER_CONFIG: begin
					// Divider field is kept unless the key is open
					if (key_open_reg) begin
						clkcfg_next = merge(clkcfg_reg, ccm_pkg::CLKCFG_MASK, wmask, wdata);
					end else begin
						clkcfg_next = merge(clkcfg_reg, ccm_pkg::CLKCFG_MASK & ~ccm_pkg::REFDIV_MASK,
							wmask, wdata) | (clkcfg_reg & ccm_pkg::REFDIV_MASK);
					end
				end
				ccm_pkg::IDX_INPUT_MIXER_CONTROL: begin
					mixctl_next = merge(mixctl_reg, ccm_pkg::MIXCTL_MASK, wmask, wdata);
				end
				ccm_pkg::IDX_LEFT_MIXER_GAINS: begin
					lgain_next = merge(lgain_reg, ccm_pkg::GAINS_MASK, wmask, wdata);
				end
				ccm_pkg::IDX_RIGHT_MIXER_GAINS: begin
					rgain_next = merge(rgain_reg, ccm_pkg::GAINS_MASK, wmask, wdata);
				end
				ccm_pkg::IDX_MIXER_SOURCE_SELECT: begin
					select_next = merge(select_reg, ccm_pkg::SELECT_MASK, wmask, wdata);
				end
				ccm_pkg::IDX_SECURITY_KEY: begin
					// A wrong value closes the key again
					if (wmask == 16'hffff) begin
						key_open_next = (wdata == ccm_pkg::KEY_VALUE);
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			clkcfg_reg <= ccm_pkg::CLKCFG_RESET;
			mixctl_reg <= ccm_pkg::MIXCTL_RESET;
			lgain_reg <= ccm_pkg::GAINS_RESET;
			rgain_reg <= ccm_pkg::GAINS_RESET;
			select_reg <= ccm_pkg::SELECT_RESET;
			key_open_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			clkcfg_reg <= clkcfg_next;
			mixctl_reg <= mixctl_next;
			lgain_reg <= lgain_next;
			rgain_reg <= rgain_next;
			select_reg <= select_next;
			key_open_reg <= key_open_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock dividers, all as enables on the system clock

	logic [2:0] db_code;
	logic [2:0] pin_code;
	logic [2:0] to_code;
	logic [5:0] ref_code;
	logic ref_tick;
	logic db_tick;
	logic to_tick;
	logic [4:0] pin_period;
	logic [4:0] pin_count;

	assign db_code = clkcfg_reg[ccm_pkg::DBDIV_LSB +: 3];
	assign pin_code = clkcfg_reg[ccm_pkg::PINDIV_LSB +: 3];
	assign to_code = clkcfg_reg[ccm_pkg::TODIV_LSB +: 3];
	assign ref_code = clkcfg_reg[ccm_pkg::REFDIV_LSB +: 6];
	assign pin_period = ccm_pkg::pin_period(pin_code);

	ccm_tick_div #(.W(7)) u_ref_div (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.en_in(1'b1),
		.period_in({1'b0, ref_code} + 7'h01),
		.tick_out(ref_tick),
		.count_out()
	);

	ccm_tick_div #(.W(18)) u_debounce_div (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.en_in(ref_tick),
		.period_in(ccm_pkg::debounce_period(db_code)),
		.tick_out(db_tick),
		.count_out()
	);

	ccm_tick_div #(.W(18)) u_timeout_div (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.en_in(ref_tick),
		.period_in(ccm_pkg::timeout_period(to_code)),
		.tick_out(to_tick),
		.count_out()
	);

	ccm_tick_div #(.W(5)) u_pin_div (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.en_in(1'b1),
		.period_in(pin_period),
		.tick_out(),
		.count_out(pin_count)
	);

	assign reference_clock_tick_out = ref_tick;
	assign debounce_clock_out = db_tick;
	assign timeout_clock_out = to_tick;

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs

	logic pin_level_reg;
	logic pin_level_next;
	logic pin_oe_reg;
	logic pin_oe_next;
	logic [3:0] en_reg;
	logic [3:0] en_next;

	always_comb begin
		pin_oe_next = pin_clock_output_enable_in;
		pin_level_next = 1'b0;
		// Divide by one would need the clock itself; a flop can only give half of it
		if (pin_clock_output_enable_in) begin
			if (pin_period == 5'h01) begin
				pin_level_next = !pin_level_reg;
			end else begin
				pin_level_next = ({pin_count, 1'b0} < {1'b0, pin_period});
			end
		end
		en_next[0] = left_input_path_enable_in;
		en_next[1] = mixctl_reg[ccm_pkg::LEN_BIT] | left_input_path_enable_in;
		en_next[2] = right_input_path_enable_in;
		en_next[3] = mixctl_reg[ccm_pkg::REN_BIT] | right_input_path_enable_in;
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_level_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
			en_reg <= 4'h0;
		end else begin
			pin_level_reg <= pin_level_next;
			pin_oe_reg <= pin_oe_next;
			en_reg <= en_next;
		end
	end

	assign pin_clock_out = pin_level_reg;
	assign pin_clock_oe_out = pin_oe_reg;
	assign left_amp_enable_out = en_reg[0];
	assign left_mixer_enable_out = en_reg[1];
	assign right_amp_enable_out = en_reg[2];
	assign right_mixer_enable_out = en_reg[3];

	// Mutes and selects are register bits; gains are decoded from register bits
	assign left_mixer_mute_out = mixctl_reg[ccm_pkg::LMUTE_BIT];
	assign right_mixer_mute_out = mixctl_reg[ccm_pkg::RMUTE_BIT];
	assign left_second_input_select_out = select_reg[ccm_pkg::LSEL_SECOND_BIT];
	assign left_third_input_select_out = select_reg[ccm_pkg::LSEL_THIRD_BIT];
	assign left_amp_select_out = select_reg[ccm_pkg::LSEL_AMP_BIT];
	assign right_second_input_select_out = select_reg[ccm_pkg::RSEL_SECOND_BIT];
	assign right_third_input_select_out = select_reg[ccm_pkg::RSEL_THIRD_BIT];
	assign right_amp_select_out = select_reg[ccm_pkg::RSEL_AMP_BIT];

	logic [35:0] gain_reg;
	logic [35:0] gain_next;

	always_comb begin
		gain_next[35:30] = ccm_pkg::input_gain_db(lgain_reg[ccm_pkg::SECOND_GAIN_LSB +: 3]);
		gain_next[29:24] = ccm_pkg::amp_gain_db(lgain_reg[ccm_pkg::AMP_GAIN_LSB +: 3]);
		gain_next[23:18] = ccm_pkg::input_gain_db(lgain_reg[ccm_pkg::THIRD_GAIN_LSB +: 3]);
		gain_next[17:12] = ccm_pkg::input_gain_db(rgain_reg[ccm_pkg::SECOND_GAIN_LSB +: 3]);
		gain_next[11:6] = ccm_pkg::amp_gain_db(rgain_reg[ccm_pkg::AMP_GAIN_LSB +: 3]);
		gain_next[5:0] = ccm_pkg::input_gain_db(rgain_reg[ccm_pkg::THIRD_GAIN_LSB +: 3]);
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			gain_reg <= 36'h0_0000_0000;
		end else begin
			gain_reg <= gain_next;
		end
	end

	assign left_second_input_gain_out = gain_reg[35:30];
	assign left_amp_to_mixer_gain_out = gain_reg[29:24];
	assign left_third_input_gain_out = gain_reg[23:18];
	assign right_second_input_gain_out = gain_reg[17:12];
	assign right_amp_to_mixer_gain_out = gain_reg[11:6];
	assign right_third_input_gain_out = gain_reg[5:0];

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n);

	sequence s_ref_tick_at_reset_rate;
		ref_tick && (ref_code == ccm_pkg::REFDIV_RESET);
	endsequence

	// A divider rewrite under the key may legally shorten the gap
	sequence s_quiet_after_tick;
		(!ref_tick || (ref_code != ccm_pkg::REFDIV_RESET)) [*8];
	endsequence

	AST_REF_SPACING: assert property (s_ref_tick_at_reset_rate |=> s_quiet_after_tick)
		else $error("reference tick repeats too soon");

	AST_DB_NEEDS_REF: assert property (db_tick |-> $past(ref_tick))
		else $error("debounce tick without reference tick");

	AST_REFDIV_LOCKED: assert property (wr_commit && !key_open_reg &&
		(idx == ccm_pkg::IDX_CLOCK_DIVIDER_CONFIG) |=> $stable(ref_code))
		else $error("divider field changed without key");

	AST_UNMAPPED_ZERO: assert property (req && !ack_reg && !wb_we_in && (idx > 8'h22) &&
		(idx != ccm_pkg::IDX_SECURITY_KEY) |=> ack_reg && (rdata_reg == 32'h0000_0000))
		else $error("unmapped read not zero");

	AST_LEFT_ENABLE: assert property (##1 left_mixer_enable_out ==
		($past(mixctl_reg[1]) || $past(left_input_path_enable_in)))
		else $error("left mixer enable wrong");

	AST_RIGHT_ENABLE: assert property (right_input_path_enable_in |=> right_mixer_enable_out
		&& right_amp_enable_out)
		else $error("right mixer enable wrong");

	AST_PIN_OFF: assert property (!pin_clock_output_enable_in [*2] |->
		!pin_clock_out && !pin_clock_oe_out)
		else $error("pin clock driven while disabled");

	AST_THIRD_GAIN: assert property ((lgain_reg[2:0] <= 3'h1) |=>
		(left_third_input_gain_out == -6'sd12))
		else $error("left third gain floor wrong");

	AST_AMP_GAIN: assert property ((rgain_reg[5:3] == 3'h3) |=>
		(right_amp_to_mixer_gain_out == 6'sd18))
		else $error("right amplifier gain decode wrong");

	AST_ACK_PULSE: assert property (req && !ack_reg |=> ack_reg ##1 !ack_reg)
		else $error("ack not a single cycle");

endmodule

`default_nettype wire

//--- ccm_tick_div.sv
// Purpose: free counter that emits a one-cycle tick every period_in advances
// Assumes: period_in of zero behaves as one
// Notes: a shrinking period wraps at once instead of running to the top
`timescale 1ns/1ps
`default_nettype none

module ccm_tick_div #(
	parameter int W = 18
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic en_in,
	input wire logic [W-1:0] period_in,
	// Result
	output logic tick_out,
	output logic [W-1:0] count_out
);

	// Elaboration-time refusal of widths the counter cannot serve
	if (W < 2) begin
		$error("ccm_tick_div: W must be at least 2");
	end

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		count_next = count_reg;
		tick_next = 1'b0;
		if (en_in) begin
			if ((count_reg + W'(1)) >= period_in) begin
				count_next = '0;
				tick_next = 1'b1;
			end else begin
				count_next = count_reg + W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_out = tick_reg;
	assign count_out = count_reg;

endmodule

`default_nettype wire

//--- tb_top.sv
// Purpose: register bank, gain decode, enable and divided clock checks
// Assumes: the key unlocks a reduced reference divider so long counts stay short
// Notes: tick counters sample on the falling edge, away from the launch edge
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic core_clk_in, rst_n_in, lpe, rpe, pce, cyc, stb, we, ack;
	logic [9:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic rtick, dtick, ttick, pclk, poe, pprev;
	logic lae, lme, lmu, l2s, l3s, las, rae, rme, rmu, r2s, r3s, ras;
	logic signed [5:0] l2g, lag, l3g, r2g, rag, r3g;
	int n_errors, cmp_count, nr, nd, nt, np, dr, dd, dt, dp, g;
	int at[8] = '{0, 6, 13, 18, 20, 24, 27, 29};

	ccm_regs dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.left_input_path_enable_in(lpe), .right_input_path_enable_in(rpe),
		.pin_clock_output_enable_in(pce), .reference_clock_tick_out(rtick),
		.debounce_clock_out(dtick), .timeout_clock_out(ttick), .pin_clock_out(pclk),
		.pin_clock_oe_out(poe), .left_amp_enable_out(lae), .left_mixer_enable_out(lme),
		.left_mixer_mute_out(lmu), .left_second_input_select_out(l2s),
		.left_third_input_select_out(l3s), .left_amp_select_out(las),
		.left_second_input_gain_out(l2g), .left_amp_to_mixer_gain_out(lag),
		.left_third_input_gain_out(l3g), .right_amp_enable_out(rae),
		.right_mixer_enable_out(rme), .right_mixer_mute_out(rmu),
		.right_second_input_select_out(r2s), .right_third_input_select_out(r3s),
		.right_amp_select_out(ras), .right_second_input_gain_out(r2g),
		.right_amp_to_mixer_gain_out(rag), .right_third_input_gain_out(r3g));

	ccm_host_model host (.clk_in(core_clk_in), .cyc_out(cyc), .stb_out(stb), .we_out(we),
		.adr_out(adr), .sel_out(sel), .dat_out(wdat), .dat_in(rdat), .ack_in(ack));

	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	always @(negedge core_clk_in) begin
		nr += rtick;
		nd += dtick;
		nt += ttick;
		np += (pclk && !pprev);
		pprev = pclk;
	end

	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d,
		output logic [31:0] q);
		bit ok;
		host.xfer(w, {idx, 2'b00}, d, q, ok);
		if (!ok) begin
			n_errors++;
			$display("[ERR] %0t bus timeout", $time);
			stop_test();
		end
	endtask

	task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 16'h0000, q);
		chk(q, {16'h0000, exp});
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
		repeat (3) @(posedge core_clk_in);
	endtask

	// Pulses seen over a window of n cycles
	task automatic span(input int n);
		int b0, b1, b2, b3;
		b0 = nr;
		b1 = nd;
		b2 = nt;
		b3 = np;
		repeat (n) @(posedge core_clk_in);
		dr = nr - b0;
		dd = nd - b1;
		dt = nt - b2;
		dp = np - b3;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		rst_n_in = 1'b0;
		{lpe, rpe, pce, pprev} = 4'h0;
		{n_errors, cmp_count, nr, nd, nt, np} = '0;
		repeat (4) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		rd(8'h1e, 16'h005e);
		rd(8'h1f, 16'h0000);
		rd(8'h20, 16'h0145);
		rd(8'h21, 16'h0145);
		rd(8'h22, 16'h0009);
		chk({l2s, l3s, las, r2s, r3s, ras}, 32'h9);
		rd(8'h30, 16'h0000);
		span(480);
		chk(dr, 32'd10);
		// Everything written with ones; protected and undefined bits must not move
		for (int i = 8'h1e; i <= 8'h22; i++) wr(8'(i), 16'hffff);
		wr(8'h30, 16'hffff);
		rd(8'h1e, 16'hffde);
		rd(8'h1f, 16'h000f);
		rd(8'h20, 16'h01ff);
		rd(8'h21, 16'h01ff);
		rd(8'h22, 16'h003f);
		rd(8'h30, 16'h0000);
		chk({lmu, rmu, l2s, l3s, las, r2s, r3s, ras}, 32'hff);
		// Enables: own bit or path enable
		wr(8'h1f, 16'h0000);
		chk({lmu, rmu, lme, rme, lae, rae}, 32'h0);
		lpe <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		chk({lme, lae, rme, rae}, 32'hc);
		lpe <= 1'b0;
		rpe <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		chk({lme, lae, rme, rae}, 32'h3);
		rpe <= 1'b0;
		wr(8'h1f, 16'h0002);
		chk({lme, lae, rme, rae}, 32'h8);
		wr(8'h1f, 16'h0001);
		chk({lme, lae, rme, rae}, 32'h2);
		// Gain decode over every code
		for (int c = 0; c < 8; c++) begin
			wr(8'h20, 16'(c * 73));
			wr(8'h21, 16'(c * 73));
			g = (c < 2) ? -12 : 3 * c - 15;
			chk(l2g, 6'(g));
			chk(l3g, 6'(g));
			chk(lag, 6'(at[c]));
			chk(r2g, 6'(g));
			chk(rag, 6'(at[c]));
			chk(r3g, 6'(g));
		end
		// Unlock, reference /4, pin /4, debounce and timeout code 001
		wr(8'h40, 16'h5a3c);
		wr(8'h1e, 16'h2c86);
		rd(8'h1e, 16'h2c86);
		pce <= 1'b1;
		repeat (8300) @(posedge core_clk_in);
		span(8192);
		chk(dr, 32'd2048);
		chk(dd, 32'd1);
		chk(dt, 32'd4);
		chk(dp, 32'd2048);
		chk(poe, 32'h1);
		wr(8'h1e, 16'h1c06);
		span(64);
		chk(dp, 32'd4);
		// Closed key: reference field keeps the value 3
		wr(8'h40, 16'h0000);
		wr(8'h1e, 16'h0000);
		rd(8'h1e, 16'h0006);
		pce <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		span(40);
		chk({poe, pclk, 30'(dp)}, 32'h0);
		stop_test();
	end
endmodule

`default_nettype wire
